// file: hw/dlsu_defines.svh
// Constants of the data load/store unit: offsets, fields, resets, map.
// Assumes inclusion by the unit and the testbench; no logic here.
// What this block does
// - Word and half-word addresses are assumed aligned; low bits are not checked.
// - Bytes, half words and words are handled, signed and unsigned.
// - Loaded byte lands in bits 7:0, upper 24 bits zero or sign.
// - Loaded half word lands in bits 15:0, upper 16 bits zero or sign.
// - A three-bit address-op field selects one of eight address operations.
// - Ops 1-6 pick register, calculated or coordinate bus and read/write; the extended op uses the pointer.
// - The memory access happens in the cycle after the address op.
// - 2D coordinates are two 16-bit fields, 3D three bytes in low word.
// - Extended op offers pre/post increment and decrement of a pointer.
// - Extended op with perspective flag (control bit 30) makes texel read addresses.
// - Perspective reads bypass the cache on their own memory controller port.
// - Perspective mode delivers up to four texels per cycle.
// - Texels convert from pseudo-color or 16-bit color to 32-bit alpha color.
// - A separate three-bit transfer field selects load, store or extend.
// - Sixteen 16 Mb banks from zero, each with its own dimension.
// - I/O space 0 is 64 kb at f000_0000 on the peripheral bus.
// - I/O space 1 is 64 kb at f001_0000, external 8-bit devices.
// - I/O space 3 is 128 kb at f002_0000, the external EPROM.
// - Eight 2D row lengths 256 to 32768 bytes and eight 3D volumes.
// - Structured access crossing its page costs one extra cycle.
// - Every bank stays reachable by plain linear byte addresses.
// - Store codes: 1,2,3,5 word from F,M,V,B; 6 half; 7 byte.
// - Narrow stores are lane-aligned and raise only matching byte enables.
// - A load runs only with read data present and no write issued.
// - Load codes 1-3 unsigned word/half/byte, 5-7 signed; 0 and 4 idle.
`ifndef DLSU_DEFINES_SVH
`define DLSU_DEFINES_SVH
`define DLSU_CTRL_OFS    11'h000
`define DLSU_BANKDIM_OFS 11'h004
`define DLSU_DBUS_OFS    11'h008
`define DLSU_STAT_OFS    11'h00C
`define DLSU_PTR_OFS     11'h010
`define DLSU_PAL_BIT     10
`define DLSU_CTRL_RST    32'h0000_0000
`define DLSU_BANKDIM_RST 32'h0000_0000
`define DLSU_PAG_BIT     30
`define DLSU_EXTWR_BIT   3
`define DLSU_INC_LSB     0
`define DLSU_FMT_LSB     4
`define DLSU_DEPTH_LSB   8
`define DLSU_BANK_LSB    16
`define DLSU_MODE_LSB    20
`define DLSU_STEP_LSB    24
`define DLSU_ROW_LOG2    4'h8
`define DLSU_VOL_LOG2    4'h6
`define DLSU_BANK_TOP    32'h1000_0000
`define DLSU_IO0_BASE    32'hF000_0000
`define DLSU_IO1_BASE    32'hF001_0000
`define DLSU_IO3_BASE    32'hF002_0000
`define DLSU_IO0_SIZE    32'h0001_0000
`define DLSU_IO1_SIZE    32'h0001_0000
`define DLSU_IO3_SIZE    32'h0002_0000
`endif

// file: hw/dlsu_pkg.sv
// Types of the data load/store unit.
// Assumes the defines header sits beside it.
package dlsu_pkg;
  // Address operations in field order
  typedef enum logic [2:0] {
    AO_NOP, AO_RD_A, AO_RD_F, AO_RD_M,
    AO_WR_A, AO_WR_F, AO_WR_M, AO_EXT
  } dlsu_aop_t;
  // Target of a decoded address
  typedef enum logic [2:0] {
    SP_MEM, SP_IO0, SP_IO1, SP_IO3, SP_NONE
  } dlsu_space_t;
  // Bank dimension codes
  typedef enum logic [1:0] {DIM_1D, DIM_2D, DIM_3D, DIM_RSV} dlsu_dim_t;
  // One memory request toward cache or peripheral bus
  typedef struct packed {
    logic        valid;
    logic        we;
    dlsu_space_t space;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } dlsu_req_t;
  typedef logic [3:0][31:0] dlsu_quad_t;
endpackage

// file: hw/dlsu_unit.sv
// Data load/store unit: address ops, transfers, map decode, texel path.
// Assumes the sequencer holds its instruction fields while stall is high.
`timescale 1ns/1ps
`include "dlsu_defines.svh"
module dlsu_unit (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic [2:0]         address_op_field,
  input  wire logic [2:0]         transfer_op_field,
  input  wire logic [31:0]        reg_bus,
  input  wire logic [31:0]        calc_bus,
  input  wire logic [31:0]        coord_bus,
  input  wire logic [31:0]        vec_bus,
  input  wire logic [31:0]        store_bus,
  input  wire logic               rd_valid,
  input  wire logic [31:0]        rd_data,
  input  wire logic               tex_in_valid,
  input  wire dlsu_pkg::dlsu_quad_t tex_in,
  input  wire logic [10:0]        reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  output logic                    stall,
  output dlsu_pkg::dlsu_req_t     cache_req,
  output dlsu_pkg::dlsu_req_t     periph_req,
  output logic                    tex_req_valid,
  output logic [31:0]             tex_addr,
  output logic                    tex_out_valid,
  output dlsu_pkg::dlsu_quad_t    tex_out,
  output logic [31:0]             d_bus
);
  import dlsu_pkg::*;

  logic [31:0] data_io_control_reg;
  logic [31:0] bank_dim;
  logic [31:0] ptr;
  logic [2:0]  status;
  logic [31:0] pal [256];
  logic [1:0]  rd_lane;
  logic [15:0] last_page;
  logic        page_valid;
  logic        pen_done;
  logic        perspective_gen_enable;
  logic        extended_address_op;
  dlsu_aop_t   aop;
  logic [31:0] src_addr;
  logic [31:0] eff_addr;
  logic [31:0] next_ptr;
  logic [31:0] step;
  logic        is_rd;
  logic        is_wr;
  logic        use_m;
  logic        structured;
  logic        go;
  logic        to_tex;
  dlsu_space_t space;
  logic [3:0]  bank;
  dlsu_dim_t   dim;
  logic [31:0] st_data;
  logic [3:0]  st_be;
  logic [1:0]  low_address_bits;
  logic        load_go;
  logic        ext_go;
  logic [7:0]  depth_mask;
  logic [3:0]  depth;

  // Zero or sign extension of a lane-aligned byte or half word
  function automatic logic [31:0] f_extend(input logic [31:0] w,
                                           input logic [1:0]  lane,
                                           input logic [2:0]  op);
    logic [31:0] s;
    s = w >> {lane, 3'b000};
    unique case (op[1:0])
      2'd2:    return op[2] ? {{16{s[15]}}, s[15:0]} : {16'h0000, s[15:0]};
      2'd3:    return op[2] ? {{24{s[7]}}, s[7:0]} : {24'h00_0000, s[7:0]};
      default: return w; // Words ignore the lane bits
    endcase
  endfunction

  // Coordinate word to linear bank address
  function automatic logic [31:0] f_struct(input logic [31:0] c,
                                           input dlsu_dim_t   d,
                                           input logic [2:0]  m,
                                           input logic [3:0]  b);
    logic [31:0] off;
    logic [3:0]  xb;
    logic [3:0]  yb;
    off = c;
    xb  = `DLSU_VOL_LOG2 + {2'b00, m[1:0]};
    yb  = `DLSU_VOL_LOG2 + {3'b000, m[2]};
    unique case (d)
      DIM_2D: off = ({16'h0000, c[31:16]} << (`DLSU_ROW_LOG2 + {1'b0, m}))
                    + {16'h0000, c[15:0]};
      DIM_3D: off = ({24'h00_0000, c[23:16]} << ({1'b0, xb} + {1'b0, yb}))
                    | ({24'h00_0000, c[15:8]} << xb) | {24'h00_0000, c[7:0]};
      default: return c; // Linear banks take the word as is
    endcase
    return {4'h0, b, off[23:0]};
  endfunction

  // Address map decode
  function automatic dlsu_space_t f_space(input logic [31:0] a);
    if (a < `DLSU_BANK_TOP)
      return SP_MEM;
    if (a >= `DLSU_IO0_BASE && a < `DLSU_IO0_BASE + `DLSU_IO0_SIZE)
      return SP_IO0;
    if (a >= `DLSU_IO1_BASE && a < `DLSU_IO1_BASE + `DLSU_IO1_SIZE)
      return SP_IO1;
    if (a >= `DLSU_IO3_BASE && a < `DLSU_IO3_BASE + `DLSU_IO3_SIZE)
      return SP_IO3;
    return SP_NONE;
  endfunction

  // Control fields
  assign perspective_gen_enable = data_io_control_reg[`DLSU_PAG_BIT];
  assign bank  = data_io_control_reg[`DLSU_BANK_LSB +: 4];
  assign dim   = dlsu_dim_t'(bank_dim[{bank, 1'b0} +: 2]);
  assign step  = {26'h000_0000, data_io_control_reg[`DLSU_STEP_LSB +: 6]};
  assign depth = data_io_control_reg[`DLSU_DEPTH_LSB +: 4];

  // Address operation decode
  always_comb begin
    aop      = dlsu_aop_t'(address_op_field);
    src_addr = reg_bus;
    is_rd    = 1'b0;
    is_wr    = 1'b0;
    use_m    = 1'b0;
    next_ptr = ptr;
    unique case (aop)
      AO_NOP: ;
      AO_RD_A: is_rd = 1'b1;
      AO_RD_F: begin
        is_rd    = 1'b1;
        src_addr = calc_bus;
      end
      AO_RD_M: begin
        is_rd    = 1'b1;
        src_addr = coord_bus;
        use_m    = 1'b1;
      end
      AO_WR_A: is_wr = 1'b1;
      AO_WR_F: begin
        is_wr    = 1'b1;
        src_addr = calc_bus;
      end
      AO_WR_M: begin
        is_wr    = 1'b1;
        src_addr = coord_bus;
        use_m    = 1'b1;
      end
      AO_EXT: begin
        is_wr    = data_io_control_reg[`DLSU_EXTWR_BIT];
        is_rd    = ~is_wr;
        src_addr = ptr;
        unique case (data_io_control_reg[`DLSU_INC_LSB +: 3])
          3'd1: next_ptr = ptr + step;
          3'd2: begin
            next_ptr = ptr + step;
            src_addr = next_ptr;
          end
          3'd3: next_ptr = ptr - step;
          3'd4: begin
            next_ptr = ptr - step;
            src_addr = next_ptr;
          end
          default: next_ptr = ptr;
        endcase
        if (perspective_gen_enable && is_rd) begin
          src_addr = coord_bus;
          use_m    = 1'b1;
        end
      end
    endcase
  end

  assign extended_address_op = (aop == AO_EXT);
  assign to_tex     = extended_address_op && perspective_gen_enable && is_rd;
  assign structured = use_m && (dim == DIM_2D || dim == DIM_3D);
  assign eff_addr   = use_m ? f_struct(src_addr, dim, data_io_control_reg[`DLSU_MODE_LSB +: 3], bank) : src_addr;
  assign space      = f_space(eff_addr);
  assign low_address_bits = eff_addr[1:0];
  // One extra cycle when a structured access leaves its page
  assign stall = structured && page_valid && (eff_addr[31:16] != last_page) && !pen_done;
  assign go    = (is_rd || is_wr) && !stall;

  // Store alignment and byte enables
  always_comb begin
    st_data = store_bus;
    st_be   = 4'h0;
    unique case (transfer_op_field)
      3'd1: begin
        st_data = calc_bus;
        st_be   = 4'hF;
      end
      3'd2: begin
        st_data = coord_bus;
        st_be   = 4'hF;
      end
      3'd3: begin
        st_data = vec_bus;
        st_be   = 4'hF;
      end
      3'd5: st_be = 4'hF;
      3'd6: begin
        st_data = {2{store_bus[15:0]}};
        st_be   = low_address_bits[1] ? 4'hC : 4'h3;
      end
      3'd7: begin
        st_data = {4{store_bus[7:0]}};
        st_be   = 4'h1 << low_address_bits;
      end
      default: st_be = 4'h0; // Codes 0 and 4 write nothing
    endcase
  end

  // Request registers, driven the cycle after the address op
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cache_req     <= '0;
      periph_req    <= '0;
      tex_req_valid <= 1'b0;
      tex_addr      <= 32'h0000_0000;
    end else begin
      cache_req.valid  <= go && !to_tex && space == SP_MEM;
      periph_req.valid <= go && space != SP_MEM && space != SP_NONE;
      tex_req_valid    <= go && to_tex;
      cache_req.we     <= is_wr;
      periph_req.we    <= is_wr;
      cache_req.space  <= space;
      periph_req.space <= space;
      cache_req.addr   <= eff_addr;
      periph_req.addr  <= eff_addr;
      cache_req.be     <= is_wr ? st_be : 4'hF;
      periph_req.be    <= is_wr ? st_be : 4'hF;
      cache_req.wdata  <= st_data;
      periph_req.wdata <= st_data;
      tex_addr         <= eff_addr;
    end
  end

  // Page tracking for the boundary penalty
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_page  <= 16'h0000;
      page_valid <= 1'b0;
      pen_done   <= 1'b0;
    end else begin
      pen_done <= stall;
      if (go && structured) begin
        last_page  <= eff_addr[31:16];
        page_valid <= 1'b1;
      end
    end
  end

  // Lane of the outstanding read
  always_ff @(posedge core_clk) begin
    if (rst)
      rd_lane <= 2'b00;
    else if (go && is_rd)
      rd_lane <= low_address_bits;
  end

  // Load or internal extension into the D register
  assign load_go = rd_valid && !is_wr;
  assign ext_go  = !rd_valid && !is_wr;
  always_ff @(posedge core_clk) begin
    if (rst)
      d_bus <= 32'h0000_0000;
    else if (reg_wr && reg_addr == `DLSU_DBUS_OFS)
      d_bus <= reg_wdata;
    else if (transfer_op_field[1:0] != 2'b00) begin
      if (load_go)
        d_bus <= f_extend(rd_data, rd_lane, transfer_op_field);
      else if (ext_go)
        d_bus <= f_extend(store_bus, 2'b00, transfer_op_field);
    end
  end

  // Extended pointer
  always_ff @(posedge core_clk) begin
    if (rst)
      ptr <= 32'h0000_0000;
    else if (reg_wr && reg_addr == `DLSU_PTR_OFS)
      ptr <= reg_wdata;
    else if (go && extended_address_op && !to_tex)
      ptr <= next_ptr;
  end

  // Software registers and palette
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_io_control_reg <= `DLSU_CTRL_RST;
      bank_dim            <= `DLSU_BANKDIM_RST;
    end else if (reg_wr) begin
      if (reg_addr == `DLSU_CTRL_OFS)
        data_io_control_reg <= reg_wdata;
      if (reg_addr == `DLSU_BANKDIM_OFS)
        bank_dim <= reg_wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reg_wr && reg_addr[`DLSU_PAL_BIT])
      pal[reg_addr[9:2]] <= reg_wdata;
  end

  // Status: unmapped sticky (write 1 clears, set wins), penalty, texel wait
  always_ff @(posedge core_clk) begin
    if (rst)
      status <= 3'b000;
    else begin
      status[1] <= stall;
      status[2] <= tex_req_valid | (status[2] & ~tex_in_valid);
      if ((is_rd || is_wr) && space == SP_NONE)
        status[0] <= 1'b1;
      else if (reg_wr && reg_addr == `DLSU_STAT_OFS && reg_wdata[0])
        status[0] <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      if (reg_addr[`DLSU_PAL_BIT])
        reg_rdata <= pal[reg_addr[9:2]];
      else
        unique case (reg_addr)
          `DLSU_CTRL_OFS:    reg_rdata <= data_io_control_reg;
          `DLSU_BANKDIM_OFS: reg_rdata <= bank_dim;
          `DLSU_DBUS_OFS:    reg_rdata <= d_bus;
          `DLSU_STAT_OFS:    reg_rdata <= {29'h0000_0000, status};
          `DLSU_PTR_OFS:     reg_rdata <= ptr;
          default:           reg_rdata <= 32'h0000_0000;
        endcase
    end else
      reg_rdata <= 32'h0000_0000;
  end

  // Pseudo-color index mask from bit depth 1..8
  assign depth_mask = (depth == 4'h0 || depth > 4'h8) ? 8'hFF : 8'(8'hFF >> (4'h8 - depth));

  // Four texel converters
  for (genvar i = 0; i < 4; i++) begin : g_tex
    logic [31:0] raw;
    logic [31:0] conv;
    assign raw = tex_in[i];
    always_comb begin
      unique case (data_io_control_reg[`DLSU_FMT_LSB +: 2])
        2'd1:    conv = pal[raw[7:0] & depth_mask];
        2'd2:    conv = {8'hFF, raw[15:11], raw[15:13], raw[10:5], raw[10:9], raw[4:0], raw[4:2]};
        default: conv = raw;
      endcase
    end
    always_ff @(posedge core_clk) begin
      if (rst)
        tex_out[i] <= 32'h0000_0000;
      else if (tex_in_valid)
        tex_out[i] <= conv;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst)
      tex_out_valid <= 1'b0;
    else
      tex_out_valid <= tex_in_valid;
  end

  // Checks
  property p_next_cycle;
    @(posedge core_clk) disable iff (rst)
      (go && !to_tex && space == SP_MEM) |=> cache_req.valid && cache_req.addr == $past(eff_addr);
  endproperty
  a_next_cycle: assert property (p_next_cycle) else $error("cache access not in next cycle");

  property p_tex_bypass;
    @(posedge core_clk) disable iff (rst)
      (go && to_tex) |=> tex_req_valid && !cache_req.valid;
  endproperty
  a_tex_bypass: assert property (p_tex_bypass) else $error("texel read touched the cache");

  property p_unmapped;
    @(posedge core_clk) disable iff (rst)
      ((is_rd || is_wr) && space == SP_NONE) |=> !cache_req.valid && !periph_req.valid && status[0];
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access issued");

  property p_penalty;
    @(posedge core_clk) disable iff (rst)
      stall |=> !stall;
  endproperty
  a_penalty: assert property (p_penalty) else $error("penalty longer than one cycle");

  property p_byte_be;
    @(posedge core_clk) disable iff (rst)
      (go && is_wr && transfer_op_field == 3'd7 && space == SP_MEM)
        |=> cache_req.be == (4'h1 << $past(low_address_bits));
  endproperty
  a_byte_be: assert property (p_byte_be) else $error("byte enable wrong");

  property p_sbyte;
    @(posedge core_clk) disable iff (rst)
      (load_go && transfer_op_field == 3'd7 && !reg_wr)
        |=> d_bus[31:8] == {24{d_bus[7]}};
  endproperty
  a_sbyte: assert property (p_sbyte) else $error("signed byte not extended");

  property p_uhalf;
    @(posedge core_clk) disable iff (rst)
      (load_go && transfer_op_field == 3'd2 && !reg_wr) |=> d_bus[31:16] == 16'h0000;
  endproperty
  a_uhalf: assert property (p_uhalf) else $error("unsigned half not zeroed");

  property p_no_load_on_write;
    @(posedge core_clk) disable iff (rst)
      (is_wr && !reg_wr) |=> $stable(d_bus);
  endproperty
  a_no_load_on_write: assert property (p_no_load_on_write) else $error("D changed during write");

  property p_io1_map;
    @(posedge core_clk) disable iff (rst)
      (go && !use_m && src_addr[31:16] == 16'hF001) |=> periph_req.valid && periph_req.space == SP_IO1;
  endproperty
  a_io1_map: assert property (p_io1_map) else $error("space 1 not on peripheral bus");
endmodule

// file: dv/dlsu_mem_model.sv
// Behavioural data cache and peripheral bus behind the load/store unit.
// Assumes one request per cycle on either port and a small aliased memory.
`timescale 1ns/1ps
module dlsu_mem_model (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire dlsu_pkg::dlsu_req_t cache_req,
  input  wire dlsu_pkg::dlsu_req_t periph_req,
  output logic                     rd_valid,
  output logic [31:0]              rd_data
);
  import dlsu_pkg::*;
  logic [31:0] mem [64];
  dlsu_req_t   req;

  // Either port may carry the access
  assign req = cache_req.valid ? cache_req : periph_req;

  // Read answer one cycle after the request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 32'h0000_0000;
    end else begin
      rd_valid <= req.valid && !req.we;
      if (req.valid && !req.we) begin
        rd_data <= mem[req.addr[7:2]];
      end else begin
        rd_data <= ~rd_data;  // Stale data never looks like a hold
      end
    end
  end

  // Only enabled byte lanes change
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (req.valid && req.we && req.be[i]) begin
        mem[req.addr[7:2]][8*i +: 8] <= req.wdata[8*i +: 8];
      end
    end
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench of the data load/store unit with a memory model.
// Assumes the defines header is on the include path; texel quads come from the bench.
`timescale 1ns/1ps
`include "dlsu_defines.svh"
module testbench;
  import dlsu_pkg::*;
  typedef struct packed {
    logic [2:0]  aop;
    logic [2:0]  top;
    logic [31:0] addr;
    dlsu_space_t sp;
    logic [3:0]  be;
    logic [31:0] wd;
  } dlsu_row_t;
  localparam logic [31:0] CB = 32'h0012_3450;
  localparam logic [31:0] MB = 32'h0034_5670;
  localparam logic [31:0] VB = 32'h0056_789C;
  localparam logic [31:0] BB = 32'h9ABC_DEF0;
  localparam dlsu_row_t ROWS [16] = '{
    '{3'h4, 3'h1, 32'h0000_0100, SP_MEM, 4'hF, CB},
    '{3'h4, 3'h2, 32'h0000_0104, SP_MEM, 4'hF, MB},
    '{3'h4, 3'h3, 32'h0000_0108, SP_MEM, 4'hF, VB},
    '{3'h4, 3'h5, 32'h0000_010C, SP_MEM, 4'hF, BB},
    '{3'h4, 3'h6, 32'h0000_0112, SP_MEM, 4'hC, 32'hDEF0_DEF0},
    '{3'h4, 3'h6, 32'h0000_0110, SP_MEM, 4'h3, 32'hDEF0_DEF0},
    '{3'h4, 3'h7, 32'h0000_0115, SP_MEM, 4'h2, 32'hF0F0_F0F0},
    '{3'h4, 3'h7, 32'h0000_0117, SP_MEM, 4'h8, 32'hF0F0_F0F0},
    '{3'h5, 3'h5, CB, SP_MEM, 4'hF, BB},
    '{3'h6, 3'h5, MB, SP_MEM, 4'hF, BB},
    '{3'h1, 3'h0, 32'h0FFF_FFFC, SP_MEM, 4'hF, 32'h0000_0000},
    '{3'h2, 3'h0, CB, SP_MEM, 4'hF, 32'h0000_0000},
    '{3'h4, 3'h5, 32'hF000_0010, SP_IO0, 4'hF, BB},
    '{3'h1, 3'h0, 32'hF001_FFFC, SP_IO1, 4'hF, 32'h0000_0000},
    '{3'h4, 3'h7, 32'hF003_FFFF, SP_IO3, 4'h8, 32'hF0F0_F0F0},
    '{3'h1, 3'h0, 32'hF004_0000, SP_NONE, 4'h0, 32'h0000_0000}
  };
  logic        core_clk, rst, rd_valid, reg_wr, reg_rd, stall;
  logic        tex_in_valid, tex_req_valid, tex_out_valid;
  logic [31:0] tex_addr;
  dlsu_quad_t  tex_in, tex_out;
  logic [2:0]  address_op_field, transfer_op_field;
  logic [31:0] reg_bus, calc_bus, coord_bus, vec_bus, store_bus;
  logic [31:0] rd_data, reg_wdata, reg_rdata, d_bus;
  logic [10:0] reg_addr;
  dlsu_req_t   cache_req, periph_req, q;
  int          fail_count, samples_checked, n;

  dlsu_unit u_dut (.core_clk(core_clk), .rst(rst), .address_op_field(address_op_field),
    .transfer_op_field(transfer_op_field), .reg_bus(reg_bus), .calc_bus(calc_bus),
    .coord_bus(coord_bus), .vec_bus(vec_bus), .store_bus(store_bus), .rd_valid(rd_valid),
    .rd_data(rd_data), .tex_in_valid(tex_in_valid), .tex_in(tex_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stall(stall), .cache_req(cache_req), .periph_req(periph_req), .tex_req_valid(tex_req_valid),
    .tex_addr(tex_addr), .tex_out_valid(tex_out_valid), .tex_out(tex_out), .d_bus(d_bus));
  dlsu_mem_model u_mem (.core_clk(core_clk), .rst(rst), .cache_req(cache_req),
    .periph_req(periph_req), .rd_valid(rd_valid), .rd_data(rd_data));

  // Clock at 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Expected load or extend result from word, lane and code
  function automatic logic [31:0] ld(input logic [31:0] w, input int ln, input int c);
    logic [31:0] s;
    s = w >> (8 * ln);
    if (c % 4 == 1) return s;
    if (c % 4 == 2) return (c > 4) ? {{16{s[15]}}, s[15:0]} : {16'h0000, s[15:0]};
    return (c > 4) ? {{24{s[7]}}, s[7:0]} : {24'h00_0000, s[7:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic rw(input logic [10:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rr(input logic [10:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask

  task automatic wait_rd();
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      #1;
      if (rd_valid === 1'b1) return;
    end
    chk(32'h0000_0000, 32'h0000_0001);
    wrap_up();
  endtask

  // Texel quad in, converted quad out one cycle later
  task automatic tx(input dlsu_quad_t t, input dlsu_quad_t e);
    @(posedge core_clk);
    tex_in_valid <= 1'b1;
    tex_in       <= t;
    @(posedge core_clk);
    tex_in_valid <= 1'b0;
    #1;
    chk(tex_out_valid, 1'b1);
    for (int i = 0; i < 4; i++) chk(tex_out[i], e[i]);
  endtask

  // Address op; counts stall cycles, then checks the request address
  task automatic str(input logic [2:0] op, input logic [31:0] c, input logic [31:0] a, output int cnt);
    @(posedge core_clk);
    address_op_field <= op;
    coord_bus        <= c;
    cnt = 0;
    #1;
    while (stall === 1'b1 && cnt < 5) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    if (stall === 1'b1) begin
      chk(32'h0000_0001, 32'h0000_0000);
      wrap_up();
    end
    @(posedge core_clk);
    address_op_field <= 3'h0;
    #1;
    chk(cache_req.addr, a);
  endtask

  // Main sequence: reset, table rows, loads, extends, registers, paging
  initial begin
    {rst, reg_wr, reg_rd, tex_in_valid} = 4'b1000;
    tex_in = '0;
    {address_op_field, transfer_op_field} = 6'h00;
    {reg_bus, calc_bus, coord_bus, vec_bus, store_bus} = {32'h0, CB, MB, VB, BB};
    {reg_addr, reg_wdata} = 43'h0;
    {fail_count, samples_checked} = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk({cache_req.valid, periph_req.valid, stall}, 32'h0000_0000);
    chk(d_bus, 32'h0000_0000);
    rr(`DLSU_CTRL_OFS, `DLSU_CTRL_RST, 32'hFFFF_FFFF);
    rr(`DLSU_BANKDIM_OFS, `DLSU_BANKDIM_RST, 32'hFFFF_FFFF);
    rr(`DLSU_STAT_OFS, 32'h0000_0000, 32'h0000_0001);
    foreach (ROWS[i]) begin
      @(posedge core_clk);
      address_op_field  <= ROWS[i].aop;
      transfer_op_field <= ROWS[i].top;
      reg_bus           <= ROWS[i].addr;
      @(posedge core_clk);
      address_op_field  <= 3'h0;
      transfer_op_field <= 3'h0;
      #1;
      q = (ROWS[i].sp == SP_MEM) ? cache_req : periph_req;
      if (ROWS[i].sp == SP_NONE) begin
        chk({cache_req.valid, periph_req.valid}, 32'h0000_0000);
      end else begin
        chk({q.valid, q.we, q.space, q.be}, {1'b1, ROWS[i].aop[2], ROWS[i].sp, ROWS[i].be});
        chk(q.addr, ROWS[i].addr);
        if (ROWS[i].aop[2]) chk(q.wdata, ROWS[i].wd);
      end
      repeat (2) @(posedge core_clk);
    end
    rr(`DLSU_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
    rw(`DLSU_STAT_OFS, 32'h0000_0001);
    rr(`DLSU_STAT_OFS, 32'h0000_0000, 32'h0000_0001);
    rr(11'h3F0, 32'h0000_0000, 32'hFFFF_FFFF);
    // Loads of every size and aligned lane from one stored word
    @(posedge core_clk);
    address_op_field  <= 3'h4;
    transfer_op_field <= 3'h5;
    reg_bus           <= 32'h0000_0040;
    store_bus         <= 32'h81F2_7E03;
    for (int c = 1; c < 8; c++) begin
      for (int l = 0; l < 4; l++) begin
        if (c == 4 || (c % 4 == 1 && l != 0) || (c % 4 == 2 && l % 2 == 1)) continue;
        @(posedge core_clk);
        address_op_field  <= 3'h1;
        transfer_op_field <= 3'(c);
        reg_bus           <= 32'h0000_0040 | l;
        @(posedge core_clk);
        address_op_field  <= 3'h0;
        wait_rd();
        @(posedge core_clk);
        #1;
        chk(d_bus, ld(32'h81F2_7E03, l, c));
      end
    end
    // Internal extend with no read waiting
    for (int c = 2; c < 8; c += 5) begin
      @(posedge core_clk);
      store_bus         <= 32'h0000_80F7;
      transfer_op_field <= 3'(c);
      @(posedge core_clk);
      #1;
      chk(d_bus, ld(32'h0000_80F7, 0, c));
    end
    @(posedge core_clk);
    transfer_op_field <= 3'h0;
    // Bank 0 as 2D: page change costs exactly one stall cycle
    rw(`DLSU_BANKDIM_OFS, 32'h0000_0001);
    str(3'h3, 32'h0001_0002, 32'h0000_0102, n);
    str(3'h3, 32'h0001_0010, 32'h0000_0110, n);
    chk(n, 32'h0000_0000);
    str(3'h3, 32'h0100_0000, 32'h0001_0000, n);
    chk(n, 32'h0000_0001);
    rw(`DLSU_CTRL_OFS, 32'h4000_0000);
    rr(`DLSU_CTRL_OFS, 32'h4000_0000, 32'hFFFF_FFFF);
    // Bank 0 as 3D in the largest volume mode
    rw(`DLSU_BANKDIM_OFS, 32'h0000_0002);
    rw(`DLSU_CTRL_OFS, 32'h0070_0000);
    str(3'h3, 32'h0001_0000, 32'h0001_0000, n);
    // Extended op: pre-increment read, then post-decrement write
    rw(`DLSU_PTR_OFS, 32'h0000_0200);
    rw(`DLSU_CTRL_OFS, 32'h0400_0002);
    str(3'h7, 32'h0000_0000, 32'h0000_0204, n);
    rr(`DLSU_PTR_OFS, 32'h0000_0204, 32'hFFFF_FFFF);
    rw(`DLSU_CTRL_OFS, 32'h0400_000B);
    str(3'h7, 32'h0000_0000, 32'h0000_0204, n);
    chk({cache_req.valid, cache_req.we}, 32'h0000_0003);
    rr(`DLSU_PTR_OFS, 32'h0000_0200, 32'hFFFF_FFFF);
    // Perspective read through the texel port, palette then 565 texels
    rw(11'h400, 32'hAAAA_5555);
    rw(11'h404, 32'h1234_5678);
    rw(`DLSU_CTRL_OFS, 32'h4000_0110);
    str(3'h7, 32'h0001_0203, 32'h0000_1083, n);
    chk({tex_req_valid, cache_req.valid}, 32'h0000_0002);
    chk(tex_addr, 32'h0000_1083);
    rr(`DLSU_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
    tx({32'h0000_0003, 32'h0000_0002, 32'h0000_0001, 32'h0000_00FE},
       {32'h1234_5678, 32'hAAAA_5555, 32'h1234_5678, 32'hAAAA_5555});
    rr(`DLSU_STAT_OFS, 32'h0000_0000, 32'h0000_0004);
    rw(`DLSU_CTRL_OFS, 32'h4000_0020);
    tx({32'h0000_0000, 32'h0000_001F, 32'h0000_07E0, 32'h0000_F800},
       {32'hFF00_0000, 32'hFF00_00FF, 32'hFF00_FF00, 32'hFFFF_0000});
    wrap_up();
  end
endmodule
